/* File: rtl/lsf_be_shift.sv */
`timescale 1ns/100ps
`default_nettype none
module lsf_be_shift (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        clr_i,
  input  wire logic        vld_i,
  input  wire logic [7:0]  byte_i,
  input  wire logic [3:0]  need_i,
  output logic      [63:0] word_o,
  output logic             done_o
);
  logic [3:0]  cnt_r;
  logic [63:0] acc_r;

  // First byte lands highest; word_o holds until the next field completes
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cnt_r  <= 4'h0;
      acc_r  <= 64'h0;
      word_o <= 64'h0;
      done_o <= 1'b0;
    end
    else if (clr_i)
    begin
      cnt_r  <= 4'h0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      if (vld_i)
      begin
        acc_r <= {acc_r[55:0], byte_i};
        if (cnt_r + 4'h1 == need_i)
        begin
          word_o <= {acc_r[55:0], byte_i};
          done_o <= 1'b1;
          cnt_r  <= 4'h0;
        end
        else
          cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: rtl/lsf_list_sweep_seq.sv */
// What this block does
// - Auto, external and single modes sweep first to last index, dwelling each step
// - Manual mode ignores first index, last index and dwell
// - Auto sweeps free-running; external mode sweeps once per trigger pulse
// - Single mode runs one sweep per sweep-go command or sweep-mode bus trigger, otherwise idles
// - Manual mode: step-up command or trigger pulse raises index by one
// - Manual mode: step-down command lowers index by one
// - First and last index commands store the sweep bounds
// - Dwell entry command sets dwell used by following steps
// - Precompute command prepares every index so the first sweep runs fast
// - List edit or list select discards the precomputed settings
// - Precomputed settings are volatile and absent after reset
// - Fast-switching table holds up to 3202 entries
// - Each switch event outputs pointed entry then moves to the next, except on the last loaded entry, where it stays
// - Bulk load: 4-byte start, 4-byte count, then 8-byte frequencies
// - Every bulk load field arrives most significant byte first
// - Pointer set command loads the table pointer
// - Stack entry load writes one frequency at 0 to 999; end closes loading
// - Stack pointer command sets the pointer within 0 to 999
// - Stack commands limit the usable table to 1000 points
// - List indexes and bounds stay within 0 to 1999
// - List trigger modes act only in list sweep mode
// - In fast-step bus trigger mode each bus trigger makes one table step
`timescale 1ns/100ps
`default_nettype none
module lsf_list_sweep_seq
  import lsf_pkg::*;
#(
  parameter logic [31:0] DWELL_RST = LSF_DWELL_RST,
  parameter int          CALC_CYC  = LSF_CALC_CYC
)(
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        cmd_valid_i,
  input  wire logic [4:0]  cmd_code_i,
  input  wire logic [31:0] cmd_arg_i,
  input  wire logic [63:0] cmd_freq_i,
  input  wire logic        pay_valid_i,
  input  wire logic [7:0]  pay_byte_i,
  input  wire logic        ext_trig_i,
  output logic             pay_ready_o,
  output logic             list_mode_o,
  output logic [3:0]       trig_mode_o,
  output logic [10:0]      list_index_o,
  output logic             index_step_o,
  output logic             sweep_busy_o,
  output logic             precomp_valid_o,
  output logic             learn_busy_o,
  output logic [11:0]      table_ptr_o,
  output logic [63:0]      table_freq_o,
  output logic             table_freq_vld_o,
  output logic             stack_limit_o,
  output logic             stack_loading_o
);
  // Command strobes
  logic c_list, c_cw, c_auto, c_extp, c_single, c_manual, c_go, c_up, c_dn;
  logic c_first, c_last, c_dwell, c_learn, c_sel, c_edit, c_tload, c_tptr;
  logic c_sload, c_send, c_sptr, c_gfast, c_gsweep, c_get;
  assign c_list   = cmd_valid_i && (cmd_code_i == CMD_LIST_MODE);
  assign c_cw     = cmd_valid_i && (cmd_code_i == CMD_CW_MODE);
  assign c_auto   = cmd_valid_i && (cmd_code_i == CMD_AUTO_TRIGGER);
  assign c_extp   = cmd_valid_i && (cmd_code_i == CMD_EXT_PULSE_TRIGGER);
  assign c_single = cmd_valid_i && (cmd_code_i == CMD_SINGLE_TRIGGER);
  assign c_manual = cmd_valid_i && (cmd_code_i == CMD_MANUAL_TRIGGER);
  assign c_up     = cmd_valid_i && (cmd_code_i == CMD_STEP_INCREMENT);
  assign c_dn     = cmd_valid_i && (cmd_code_i == CMD_STEP_DECREMENT);
  assign c_first  = cmd_valid_i && (cmd_code_i == CMD_SWEEP_FIRST_INDEX);
  assign c_last   = cmd_valid_i && (cmd_code_i == CMD_SWEEP_LAST_INDEX);
  assign c_dwell  = cmd_valid_i && (cmd_code_i == CMD_DWELL_ENTRY);
  assign c_learn  = cmd_valid_i && (cmd_code_i == CMD_PRECOMPUTE_LIST);
  assign c_sel    = cmd_valid_i && (cmd_code_i == CMD_LIST_SELECT);
  assign c_edit   = cmd_valid_i && (cmd_code_i == CMD_LIST_EDIT);
  assign c_tload  = cmd_valid_i && (cmd_code_i == CMD_TABLE_BULK_LOAD);
  assign c_tptr   = cmd_valid_i && (cmd_code_i == CMD_TABLE_POINTER_SET);
  assign c_sload  = cmd_valid_i && (cmd_code_i == CMD_STACK_ENTRY_LOAD);
  assign c_send   = cmd_valid_i && (cmd_code_i == CMD_STACK_LOAD_END);
  assign c_sptr   = cmd_valid_i && (cmd_code_i == CMD_STACK_POINTER_SET);
  assign c_gfast  = cmd_valid_i && (cmd_code_i == CMD_BUS_TRIG_FAST_STEP);
  assign c_gsweep = cmd_valid_i && (cmd_code_i == CMD_BUS_TRIG_SWEEP);
  assign c_get    = cmd_valid_i && (cmd_code_i == CMD_GROUP_EXEC_TRIGGER);

  logic        list_mode_r;
  lsf_trig_e   trig_r;
  lsf_seq_e    seq_r;
  logic [10:0] idx_r;
  logic [10:0] first_r;
  logic [10:0] last_r;
  logic [31:0] dwell_r;
  logic [31:0] tmr_r;
  logic        step_r;
  logic        done_r;
  logic        warm_r;
  logic        lrn_busy_r;
  logic [10:0] lrn_idx_r;
  logic [15:0] lrn_tmr_r;
  logic        fast_sel_r;
  logic        ext_rise;

  // Out-of-range indexes saturate at the top of the list
  function automatic logic [10:0] clamp_idx(input logic [31:0] a);
    return (a > {21'h0, LSF_IDX_MAX}) ? LSF_IDX_MAX : a[10:0];
  endfunction

  lsf_trig_sync u_trig_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .pin_i     (ext_trig_i),
    .rise_o    (ext_rise)
  );

  // Sweep mode and trigger selection
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      list_mode_r <= 1'b0;
      trig_r      <= TRIG_AUTO;
    end
    else
    begin
      if (c_list)
        list_mode_r <= 1'b1;
      else if (c_cw)
        list_mode_r <= 1'b0;
      if (c_auto)
        trig_r <= TRIG_AUTO;
      else if (c_extp)
        trig_r <= TRIG_EXTP;
      else if (c_single)
        trig_r <= TRIG_SINGLE;
      else if (c_manual)
        trig_r <= TRIG_MANUAL;
    end
  end

  // Sweep bounds and dwell; a zero dwell still holds one cycle
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      first_r <= 11'h000;
      last_r  <= LSF_IDX_MAX;
      dwell_r <= DWELL_RST;
    end
    else
    begin
      if (c_first)
        first_r <= clamp_idx(cmd_arg_i);
      if (c_last)
        last_r <= clamp_idx(cmd_arg_i);
      if (c_dwell)
        dwell_r <= (cmd_arg_i == 32'h0) ? 32'h1 : cmd_arg_i;
    end
  end

  logic        manual;
  logic        go;
  logic        start_req;
  logic        man_up;
  logic [31:0] step_ld;
  assign manual  = (trig_r == TRIG_MANUAL);
  // Bus trigger defaults to firing a single sweep
  assign c_go    = (cmd_valid_i && (cmd_code_i == CMD_SWEEP_GO)) || (c_get && !fast_sel_r);
  assign go      = c_go;
  assign start_req = list_mode_r && (seq_r == SEQ_IDLE) &&
                     ((trig_r == TRIG_AUTO) ||
                      ((trig_r == TRIG_EXTP) && ext_rise) ||
                      ((trig_r == TRIG_SINGLE) && go));
  assign man_up  = c_up || ext_rise;
  // Without precomputed settings each step also pays the calculation time
  assign step_ld = dwell_r - 32'h1 + (warm_r ? 32'h0 : 32'(CALC_CYC));

  // List sequencer: index, dwell timer and run state
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      seq_r  <= SEQ_IDLE;
      idx_r  <= 11'h000;
      tmr_r  <= 32'h0;
      step_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      step_r <= 1'b0;
      done_r <= 1'b0;
      if (!list_mode_r || manual)
      begin
        seq_r <= SEQ_IDLE;
        if (list_mode_r && man_up && (idx_r != LSF_IDX_MAX))
        begin
          idx_r  <= idx_r + 11'h001;
          step_r <= 1'b1;
        end
        else if (list_mode_r && c_dn && (idx_r != 11'h000))
        begin
          idx_r  <= idx_r - 11'h001;
          step_r <= 1'b1;
        end
      end
      else
      begin
        unique case (seq_r)
          SEQ_IDLE:
          begin
            if (start_req)
            begin
              seq_r  <= SEQ_RUN;
              idx_r  <= first_r;
              tmr_r  <= step_ld;
              step_r <= 1'b1;
            end
          end
          SEQ_RUN:
          begin
            if (tmr_r != 32'h0)
              tmr_r <= tmr_r - 32'h1;
            else if (idx_r == last_r)
            begin
              seq_r  <= SEQ_IDLE;
              done_r <= 1'b1;
            end
            else
            begin
              idx_r  <= (idx_r < last_r) ? idx_r + 11'h001 : idx_r - 11'h001;
              tmr_r  <= step_ld;
              step_r <= 1'b1;
            end
          end
        endcase
      end
    end
  end

  logic inval;
  assign inval = c_sel || c_edit;

  // Precompute engine; an edit aborts a pass in flight, so clear beats set
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      warm_r     <= 1'b0;
      lrn_busy_r <= 1'b0;
      lrn_idx_r  <= 11'h000;
      lrn_tmr_r  <= 16'h0;
    end
    else if (inval)
    begin
      warm_r     <= 1'b0;
      lrn_busy_r <= 1'b0;
    end
    else
    begin
      if (done_r)
        warm_r <= 1'b1;
      if (c_learn && !lrn_busy_r)
      begin
        lrn_busy_r <= 1'b1;
        lrn_idx_r  <= 11'h000;
        lrn_tmr_r  <= 16'(CALC_CYC - 1);
      end
      else if (lrn_busy_r)
      begin
        if (lrn_tmr_r != 16'h0)
          lrn_tmr_r <= lrn_tmr_r - 16'h1;
        else if (lrn_idx_r == LSF_IDX_MAX)
        begin
          lrn_busy_r <= 1'b0;
          warm_r     <= 1'b1;
        end
        else
        begin
          lrn_idx_r <= lrn_idx_r + 11'h001;
          lrn_tmr_r <= 16'(CALC_CYC - 1);
        end
      end
    end
  end

  // Bulk table load parser; one payload byte per two cycles at most
  lsf_prs_e    prs_r;
  logic [31:0] start_loc_r;
  logic [31:0] remain_r;
  logic [31:0] wr_addr_r;
  logic        rdy_r;
  logic        accept;
  logic        sh_done;
  logic [63:0] sh_word;
  assign accept = pay_valid_i && rdy_r;

  lsf_be_shift u_be_shift (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .clr_i     (prs_r == PRS_IDLE),
    .vld_i     (accept),
    .byte_i    (pay_byte_i),
    .need_i    ((prs_r == PRS_DATA) ? LSF_FREQ_BYTES : LSF_LOC_BYTES),
    .word_o    (sh_word),
    .done_o    (sh_done)
  );

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prs_r       <= PRS_IDLE;
      start_loc_r <= 32'h0;
      remain_r    <= 32'h0;
      wr_addr_r   <= 32'h0;
      rdy_r       <= 1'b0;
    end
    else
    begin
      rdy_r <= !accept && (prs_r != PRS_IDLE);
      unique case (prs_r)
        PRS_IDLE:
        begin
          if (c_tload)
          begin
            prs_r <= PRS_START;
            rdy_r <= 1'b1;
          end
        end
        PRS_START:
        begin
          if (sh_done)
          begin
            start_loc_r <= sh_word[31:0];
            prs_r       <= PRS_COUNT;
          end
        end
        PRS_COUNT:
        begin
          if (sh_done)
          begin
            remain_r  <= sh_word[31:0];
            wr_addr_r <= start_loc_r;
            if (sh_word[31:0] == 32'h0)
            begin
              prs_r <= PRS_IDLE;
              rdy_r <= 1'b0;
            end
            else
              prs_r <= PRS_DATA;
          end
        end
        PRS_DATA:
        begin
          if (sh_done)
          begin
            wr_addr_r <= wr_addr_r + 32'h1;
            remain_r  <= remain_r - 32'h1;
            if (remain_r == 32'h1)
            begin
              prs_r <= PRS_IDLE;
              rdy_r <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // Frequency table and stack limit
  logic [63:0] tbl_mem [LSF_TBL_DEPTH];
  logic        stk_mode_r;
  logic        stk_open_r;
  logic [11:0] top_r;
  logic [11:0] lim;
  logic [11:0] top_eff;
  logic        prs_we;
  logic        stk_we;
  logic        we;
  logic [11:0] we_addr;
  logic [63:0] we_data;
  assign lim     = stk_mode_r ? LSF_STACK_LIMIT : LSF_TBL_LIMIT;
  assign top_eff = (top_r > lim) ? lim : top_r;
  // Words that fall beyond the table are consumed and dropped
  assign prs_we  = sh_done && (prs_r == PRS_DATA) && (wr_addr_r < {20'h0, lim});
  assign stk_we  = c_sload && (prs_r == PRS_IDLE) &&
                   (cmd_arg_i < {20'h0, LSF_STACK_LIMIT});
  assign we      = prs_we || stk_we;
  assign we_addr = prs_we ? wr_addr_r[11:0] : cmd_arg_i[11:0];
  assign we_data = prs_we ? sh_word : cmd_freq_i;

  // Table storage has no reset; contents are undefined until loaded
  always_ff @(posedge sys_clk_i)
  begin
    if (we)
      tbl_mem[we_addr] <= we_data;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      top_r      <= 12'h000;
      stk_mode_r <= 1'b0;
      stk_open_r <= 1'b0;
    end
    else
    begin
      if (we && (we_addr >= top_r))
        top_r <= we_addr + 12'h001;
      if (c_sload || c_send || c_sptr)
        stk_mode_r <= 1'b1;
      else if (c_tload)
        stk_mode_r <= 1'b0;
      if (c_sload)
        stk_open_r <= 1'b1;
      else if (c_send)
        stk_open_r <= 1'b0;
    end
  end

  logic        fast_step;
  logic [11:0] ptr_r;
  logic [63:0] freq_r;
  logic        fvld_r;
  assign fast_step = c_get && fast_sel_r;

  // Table pointer and fast-switch output
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      fast_sel_r <= 1'b0;
      ptr_r      <= 12'h000;
      freq_r     <= 64'h0;
      fvld_r     <= 1'b0;
    end
    else
    begin
      fvld_r <= 1'b0;
      if (c_gfast)
        fast_sel_r <= 1'b1;
      else if (c_gsweep)
        fast_sel_r <= 1'b0;
      if (c_tptr)
        ptr_r <= (cmd_arg_i < {20'h0, lim}) ? cmd_arg_i[11:0] : lim - 12'h001;
      else if (c_sptr)
        ptr_r <= (cmd_arg_i < {20'h0, LSF_STACK_LIMIT}) ?
                 cmd_arg_i[11:0] : LSF_STACK_LIMIT - 12'h001;
      else if (fast_step && (ptr_r < top_eff))
      begin
        freq_r <= tbl_mem[ptr_r];
        fvld_r <= 1'b1;
        if (ptr_r + 12'h001 < top_eff)
          ptr_r <= ptr_r + 12'h001;
      end
    end
  end

  assign pay_ready_o      = rdy_r;
  assign list_mode_o      = list_mode_r;
  assign trig_mode_o      = trig_r;
  assign list_index_o     = idx_r;
  assign index_step_o     = step_r;
  assign sweep_busy_o     = seq_r[1]; // Run bit of the one-hot state, straight from its flop
  assign precomp_valid_o  = warm_r;
  assign learn_busy_o     = lrn_busy_r;
  assign table_ptr_o      = ptr_r;
  assign table_freq_o     = freq_r;
  assign table_freq_vld_o = fvld_r;
  assign stack_limit_o    = stk_mode_r;
  assign stack_loading_o  = stk_open_r;

  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_SWEEP_START: assert property (
    start_req && !manual |=> (seq_r == SEQ_RUN) && (idx_r == $past(first_r)))
    else $error("sweep did not start at first index");
  AST_MANUAL_IDLE: assert property (
    manual |=> (seq_r == SEQ_IDLE))
    else $error("sweep ran in manual mode");
  AST_EXT_WAIT: assert property (
    list_mode_r && (trig_r == TRIG_EXTP) && (seq_r == SEQ_IDLE) && !ext_rise
    |=> (seq_r == SEQ_IDLE))
    else $error("external mode swept without a pulse");
  AST_SINGLE_WAIT: assert property (
    (trig_r == TRIG_SINGLE) && (seq_r == SEQ_IDLE) && !go |=> (seq_r == SEQ_IDLE))
    else $error("single mode swept without go");
  AST_MAN_UP: assert property (
    list_mode_r && manual && man_up && (idx_r != LSF_IDX_MAX)
    |=> (idx_r == $past(idx_r) + 11'h001) && step_r)
    else $error("manual increment wrong");
  AST_MAN_DN: assert property (
    list_mode_r && manual && !man_up && c_dn && (idx_r != 11'h000)
    |=> (idx_r == $past(idx_r) - 11'h001))
    else $error("manual decrement wrong");
  AST_INVALIDATE: assert property (
    inval |=> !warm_r && !lrn_busy_r)
    else $error("precompute kept after list change");
  AST_DWELL_HOLD: assert property (
    (seq_r == SEQ_RUN) && (tmr_r != 32'h0) && list_mode_r && !manual |=> $stable(idx_r))
    else $error("index moved before dwell expired");
  AST_IDX_RANGE: assert property (
    idx_r <= LSF_IDX_MAX)
    else $error("list index out of range");
  AST_BULK_ORDER: assert property (
    (prs_r == PRS_COUNT) && sh_done && (sh_word[31:0] != 32'h0)
    |=> (prs_r == PRS_DATA) && (wr_addr_r == $past(start_loc_r)))
    else $error("bulk load did not start at its location");
  AST_FAST_STEP: assert property (
    fast_step && !c_tptr && !c_sptr && (ptr_r + 12'h001 < top_eff)
    |=> fvld_r && (ptr_r == $past(ptr_r) + 12'h001))
    else $error("fast step did not advance pointer");
  AST_STACK_CAP: assert property (
    stk_mode_r && c_tptr |=> (ptr_r < LSF_STACK_LIMIT))
    else $error("pointer beyond stack limit");

  COV_SINGLE_DONE: cover property ((trig_r == TRIG_SINGLE) && done_r);
  COV_LEARN_DONE: cover property ($fell(lrn_busy_r) && warm_r);
  COV_BULK_DONE: cover property ((prs_r == PRS_DATA) ##1 (prs_r == PRS_IDLE));
  COV_FAST_STEP: cover property (fvld_r ##[1:20] fvld_r);
endmodule
`default_nettype wire

/* File: rtl/lsf_pkg.sv */
`default_nettype none
package lsf_pkg;
  // System clock rate
  localparam int LSF_CLK_HZ = 25_000_000;
  // List index range, 0 through 1999
  localparam int         LSF_IDX_W   = 11;
  localparam logic [10:0] LSF_IDX_MAX = 11'h7CF;
  // Fast-switching table, full and stack-limited sizes
  localparam int          LSF_TBL_DEPTH   = 3202;
  localparam int          LSF_PTR_W       = 12;
  localparam logic [11:0] LSF_TBL_LIMIT   = 12'hC82;
  localparam logic [11:0] LSF_STACK_LIMIT = 12'h3E8;
  // Payload field sizes in bytes
  localparam logic [3:0] LSF_LOC_BYTES  = 4'h4;
  localparam logic [3:0] LSF_FREQ_BYTES = 4'h8;
  // Per-index calculation time when nothing is precomputed
  localparam int LSF_CALC_NS  = 1000;
  localparam int LSF_CALC_CYC = (LSF_CALC_NS * (LSF_CLK_HZ / 1_000_000) + 999) / 1000;
  // Dwell after reset, in clock cycles (1 ms)
  localparam logic [31:0] LSF_DWELL_RST = 32'h0000_61A8;

  // Decoded command codes from the bus controller
  typedef enum logic [4:0] {
    CMD_LIST_MODE          = 5'h01,
    CMD_CW_MODE            = 5'h02,
    CMD_AUTO_TRIGGER       = 5'h03,
    CMD_EXT_PULSE_TRIGGER  = 5'h04,
    CMD_SINGLE_TRIGGER     = 5'h05,
    CMD_MANUAL_TRIGGER     = 5'h06,
    CMD_SWEEP_GO           = 5'h07,
    CMD_STEP_INCREMENT     = 5'h08,
    CMD_STEP_DECREMENT     = 5'h09,
    CMD_SWEEP_FIRST_INDEX  = 5'h0A,
    CMD_SWEEP_LAST_INDEX   = 5'h0B,
    CMD_DWELL_ENTRY        = 5'h0C,
    CMD_PRECOMPUTE_LIST    = 5'h0D,
    CMD_LIST_SELECT        = 5'h0E,
    CMD_LIST_EDIT          = 5'h0F,
    CMD_TABLE_BULK_LOAD    = 5'h10,
    CMD_TABLE_POINTER_SET  = 5'h11,
    CMD_STACK_ENTRY_LOAD   = 5'h12,
    CMD_STACK_LOAD_END     = 5'h13,
    CMD_STACK_POINTER_SET  = 5'h14,
    CMD_BUS_TRIG_FAST_STEP = 5'h15,
    CMD_BUS_TRIG_SWEEP     = 5'h16,
    CMD_GROUP_EXEC_TRIGGER = 5'h17
  } lsf_cmd_e;

  typedef enum logic [3:0] {
    TRIG_AUTO   = 4'h1,
    TRIG_EXTP   = 4'h2,
    TRIG_SINGLE = 4'h4,
    TRIG_MANUAL = 4'h8
  } lsf_trig_e;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'h1,
    SEQ_RUN  = 2'h2
  } lsf_seq_e;

  typedef enum logic [3:0] {
    PRS_IDLE  = 4'h1,
    PRS_START = 4'h2,
    PRS_COUNT = 4'h4,
    PRS_DATA  = 4'h8
  } lsf_prs_e;
endpackage
`default_nettype wire

/* File: rtl/lsf_trig_sync.sv */
`timescale 1ns/100ps
`default_nettype none
module lsf_trig_sync (
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic pin_i,
  output logic      rise_o
);
  logic meta_r;
  logic samp_r;
  logic hold_r;
  logic lvl_r;

  // Three stages; a level counts once the last two agree
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_r <= 1'b0;
      samp_r <= 1'b0;
      hold_r <= 1'b0;
      lvl_r  <= 1'b0;
      rise_o <= 1'b0;
    end
    else
    begin
      meta_r <= pin_i;
      samp_r <= meta_r;
      hold_r <= samp_r;
      if (samp_r == hold_r)
        lvl_r <= hold_r;
      rise_o <= (samp_r == hold_r) && hold_r && !lvl_r;
    end
  end
endmodule
`default_nettype wire

/* File: testbench/lsf_ctl_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Bus controller stand-in: one command strobe per call, payload bytes under ready
module lsf_ctl_model
  import lsf_pkg::*;
(
  input  wire logic        sys_clk_i,
  input  wire logic        pay_ready_i,
  output logic             cmd_valid_o,
  output logic [4:0]       cmd_code_o,
  output logic [31:0]      cmd_arg_o,
  output logic [63:0]      cmd_freq_o,
  output logic             pay_valid_o,
  output logic [7:0]       pay_byte_o,
  output logic             ext_trig_o
);
  initial
  begin
    cmd_valid_o = 1'b0;
    cmd_code_o  = 5'h00;
    cmd_arg_o   = 32'h0000_0000;
    cmd_freq_o  = 64'h0;
    pay_valid_o = 1'b0;
    pay_byte_o  = 8'h00;
    ext_trig_o  = 1'b0;
  end
  // Single-cycle strobe; a gap edge always follows
  task automatic send(input lsf_cmd_e c, input logic [31:0] a);
    @(posedge sys_clk_i);
    cmd_valid_o <= 1'b1;
    cmd_code_o  <= c;
    cmd_arg_o   <= a;
    @(posedge sys_clk_i);
    cmd_valid_o <= 1'b0;
  endtask
  // Stack entry: the frequency settles a cycle ahead of its strobe
  task automatic load(input logic [31:0] a, input logic [63:0] f);
    cmd_freq_o <= f;
    send(CMD_STACK_ENTRY_LOAD, a);
  endtask
  // Hold byte until taken; afterwards show the inverse so stale data never matches
  task automatic put(input logic [7:0] b);
    int n;
    @(posedge sys_clk_i);
    pay_valid_o <= 1'b1;
    pay_byte_o  <= b;
    n = 0;
    do
    begin
      @(posedge sys_clk_i);
      n++;
    end
    while (!pay_ready_i && n < 50);
    pay_valid_o <= 1'b0;
    pay_byte_o  <= ~b;
  endtask
  // Fields go out most significant byte first
  task automatic put_word(input logic [63:0] w, input int nbytes);
    for (int i = nbytes - 1; i >= 0; i--)
      put(w[i*8 +: 8]);
  endtask
  // Trigger pulse long enough for the three-flop synchroniser
  task automatic pulse();
    @(posedge sys_clk_i);
    ext_trig_o <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    ext_trig_o <= 1'b0;
    repeat (6) @(posedge sys_clk_i);
  endtask
endmodule
`default_nettype wire

/* File: testbench/lsf_list_sweep_and_freq_table_sequencer_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module list_sweep_and_freq_table_sequencer_tb
  import lsf_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic rst_n_i   = 1'b0;
  logic cv, pv, pr, xt, vld;
  logic [4:0] cc;
  logic [31:0] ca;
  logic [63:0] cf, tf;
  logic [7:0] pb;
  logic [10:0] idx;
  logic [11:0] ptr;
  logic [3:0] tm;
  logic busy, pcv;
  logic lm, st, lb, sl, slim;
  int miscompares = 0;
  int total_checks = 0;
  always #20 sys_clk_i = ~sys_clk_i;
  lsf_ctl_model ctl (.sys_clk_i(sys_clk_i), .pay_ready_i(pr), .cmd_valid_o(cv),
    .cmd_code_o(cc), .cmd_arg_o(ca), .cmd_freq_o(cf), .pay_valid_o(pv),
    .pay_byte_o(pb), .ext_trig_o(xt));
  // Short dwell and calculation time keep the run brief
  lsf_list_sweep_seq #(.DWELL_RST(32'h0000_0004), .CALC_CYC(2)) dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .cmd_valid_i(cv), .cmd_code_i(cc),
    .cmd_arg_i(ca), .cmd_freq_i(cf), .pay_valid_i(pv), .pay_byte_i(pb),
    .ext_trig_i(xt), .pay_ready_o(pr), .list_mode_o(lm), .trig_mode_o(tm),
    .list_index_o(idx), .index_step_o(st), .sweep_busy_o(busy),
    .precomp_valid_o(pcv), .learn_busy_o(lb), .table_ptr_o(ptr),
    .table_freq_o(tf), .table_freq_vld_o(vld), .stack_limit_o(slim),
    .stack_loading_o(sl));
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Counts edges until the sweep ends; running out of the limit is a mismatch
  task automatic wait_idle(output int n);
    n = 0;
    while (busy && n < 200)
    begin
      @(posedge sys_clk_i);
      #1 n++;
    end
    if (busy)
      miscompares++;
  endtask
  task automatic conclude();
    if (miscompares == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Watchdog sized well beyond the whole sequence
  initial
  begin
    #(3000 * 40);
    miscompares++;
    conclude();
  end
  initial
  begin
    int n;
    repeat (6) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk(tm, TRIG_AUTO);
    chk(pcv, 1'b0);
    // Manual stepping by command and by trigger pin
    ctl.send(CMD_LIST_MODE, 0);
    ctl.send(CMD_MANUAL_TRIGGER, 0);
    ctl.send(CMD_STEP_INCREMENT, 0);
    ctl.send(CMD_STEP_INCREMENT, 0);
    ctl.send(CMD_STEP_DECREMENT, 0);
    #1 chk(idx, 11'h001);
    chk(st, 1'b1);
    chk(lm, 1'b1);
    ctl.pulse();
    #1 chk(idx, 11'h002);
    // Bulk load two entries at 12, then step through them by bus trigger
    ctl.send(CMD_TABLE_BULK_LOAD, 0);
    ctl.put_word(64'hC, 4);
    ctl.put_word(64'h2, 4);
    ctl.put_word(64'h41C1_E1A3_0000_0000, 8);
    ctl.put_word(64'h41FD_CD65_0000_0000, 8);
    ctl.send(CMD_TABLE_POINTER_SET, 12);
    #1 chk(ptr, 12'h00C);
    ctl.send(CMD_BUS_TRIG_FAST_STEP, 0);
    ctl.send(CMD_GROUP_EXEC_TRIGGER, 0);
    #1 chk(tf, 64'h41C1_E1A3_0000_0000);
    chk(ptr, 12'h00D);
    chk(vld, 1'b1);
    ctl.send(CMD_GROUP_EXEC_TRIGGER, 0);
    #1 chk(tf, 64'h41FD_CD65_0000_0000);
    // Single sweep 5..7 runs once and stops at the last index
    ctl.send(CMD_SWEEP_FIRST_INDEX, 5);
    ctl.send(CMD_SWEEP_LAST_INDEX, 7);
    ctl.send(CMD_DWELL_ENTRY, 3);
    ctl.send(CMD_SINGLE_TRIGGER, 0);
    ctl.send(CMD_SWEEP_GO, 0);
    #1 chk(busy, 1'b1);
    chk(idx, 11'h005);
    // Three indexes, each dwell 3 plus calculation 2 cycles
    wait_idle(n);
    chk(n, 15);
    chk(idx, 11'h007);
    repeat (20) @(posedge sys_clk_i);
    #1 chk(busy, 1'b0);
    chk(pcv, 1'b1);
    // Second go runs at full speed, dwell only
    ctl.send(CMD_SWEEP_GO, 0);
    #1 chk(busy, 1'b1);
    wait_idle(n);
    chk(n, 9);
    // External mode waits for a pulse, then sweeps once
    ctl.send(CMD_EXT_PULSE_TRIGGER, 0);
    repeat (12) @(posedge sys_clk_i);
    #1 chk(busy, 1'b0);
    ctl.pulse();
    #1 chk(busy, 1'b1);
    wait_idle(n);
    chk(idx, 11'h007);
    // Auto mode restarts by itself; manual stops it on index 7
    ctl.send(CMD_AUTO_TRIGGER, 0);
    repeat (25) @(posedge sys_clk_i);
    #1 chk(busy, 1'b1);
    ctl.send(CMD_MANUAL_TRIGGER, 0);
    // A list edit aborts a precompute pass and drops the settings
    ctl.send(CMD_PRECOMPUTE_LIST, 0);
    #1 chk(lb, 1'b1);
    ctl.send(CMD_LIST_EDIT, 0);
    #1 chk(lb, 1'b0);
    chk(pcv, 1'b0);
    // Stack loading and its 1000-point limit
    ctl.load(3, 64'h4202_A05F_2000_0000);
    #1 chk(sl, 1'b1);
    ctl.send(CMD_STACK_LOAD_END, 0);
    #1 chk(sl, 1'b0);
    ctl.send(CMD_STACK_POINTER_SET, 3);
    #1 chk(ptr, 12'h003);
    chk(slim, 1'b1);
    ctl.send(CMD_GROUP_EXEC_TRIGGER, 0);
    #1 chk(tf, 64'h4202_A05F_2000_0000);
    ctl.send(CMD_TABLE_POINTER_SET, 1500);
    #1 chk(ptr, 12'h3E7);
    ctl.send(CMD_STACK_POINTER_SET, 1200);
    #1 chk(ptr, 12'h3E7);
    // Out of list mode the step commands do nothing
    ctl.send(CMD_CW_MODE, 0);
    #1 chk(lm, 1'b0);
    ctl.send(CMD_STEP_INCREMENT, 0);
    #1 chk(idx, 11'h007);
    conclude();
  end
endmodule
`default_nettype wire
